// ===== verilog/stamp_params.svh
`ifndef STAMP_PARAMS_SVH
`define STAMP_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_INPUTS 16
`define WORD_BITS 32
`define STAMP_BITS 64
`define INTERVAL_BITS 32

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STAMP_RESET 64'h0000_0000_0000_0000
`define WORD_RESET 32'h0000_0000
`define INTERVAL_RESET 32'h0000_0000
`define INPUT_RESET 16'h0000

`endif

// ===== verilog/stamp_pkg.sv
`include "stamp_params.svh"

package stamp_pkg;

	// ----------------------------------------
	// Report carrier
	// ----------------------------------------
	typedef struct packed {
		logic [`WORD_BITS-1:0] fault_bits;
		logic [`WORD_BITS-1:0] level_bits;
		logic [`WORD_BITS-1:0] fresh_stamp_bits;
		logic [`WORD_BITS-1:0] stamp_overrun_bits;
	} status_words_t;

	typedef logic [`STAMP_BITS-1:0] stamp_t;

	typedef enum logic {
		EVERY_EDGE,
		FIRST_EDGE
	} hold_policy_t;

endpackage : stamp_pkg

// ===== verilog/per_point_transition_timestamper.sv
`timescale 1ns/1ns
`include "stamp_params.svh"

module per_point_transition_timestamper (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [`NUM_INPUTS-1:0] FILTERED_LEVEL,
	input wire logic [`NUM_INPUTS-1:0] CHATTER_DETECTED,
	input wire logic [`NUM_INPUTS-1:0] RISE_CAPTURE_ENABLE,
	input wire logic [`NUM_INPUTS-1:0] FALL_CAPTURE_ENABLE,
	input wire logic FIRST_EDGE_HOLD,
	input wire logic [`INTERVAL_BITS-1:0] PERIODIC_UPDATE_INTERVAL,
	input wire logic [`NUM_INPUTS-1:0] EVENT_ACKNOWLEDGE,
	input wire logic [`NUM_INPUTS-1:0] NEW_SAMPLE_ACKNOWLEDGE,
	input wire logic RESET_ALL_EVENTS,
	input wire logic [3:0] READ_INDEX,
	output logic REPORT_VALID,
	output stamp_pkg::status_words_t STATUS,
	output logic [`WORD_BITS-1:0] RISE_TIME_LOW,
	output logic [`WORD_BITS-1:0] RISE_TIME_HIGH,
	output logic [`WORD_BITS-1:0] FALL_TIME_LOW,
	output logic [`WORD_BITS-1:0] FALL_TIME_HIGH,
	output logic [`STAMP_BITS-1:0] SYSTEM_TIME
);

	// ----------------------------------------
	// Time base and edge detect
	// ----------------------------------------
	logic [`STAMP_BITS-1:0] time_count;
	logic [`NUM_INPUTS-1:0] level_prev;
	logic [`NUM_INPUTS-1:0] fresh;
	logic [`NUM_INPUTS-1:0] overrun;
	logic [`NUM_INPUTS-1:0] rise_held;
	logic [`NUM_INPUTS-1:0] fall_held;
	logic [`NUM_INPUTS-1:0] accept;
	logic [`NUM_INPUTS-1:0] next_fresh;
	logic [`NUM_INPUTS-1:0] next_overrun;
	logic [`INTERVAL_BITS-1:0] interval_count;
	stamp_pkg::stamp_t rising_edge_time [`NUM_INPUTS];
	stamp_pkg::stamp_t falling_edge_time [`NUM_INPUTS];
	stamp_pkg::hold_policy_t policy;

	wire [`NUM_INPUTS-1:0] rise_edge = FILTERED_LEVEL & ~level_prev;
	wire [`NUM_INPUTS-1:0] fall_edge = ~FILTERED_LEVEL & level_prev;
	// Both acknowledges must be high together to re-arm a point
	wire [`NUM_INPUTS-1:0] ack = EVENT_ACKNOWLEDGE & NEW_SAMPLE_ACKNOWLEDGE;
	wire any_accept = |accept;
	// Intervals of 0 and 1 both mean a report every cycle
	wire short_interval = (PERIODIC_UPDATE_INTERVAL < 32'h0000_0002);
	wire [`INTERVAL_BITS-1:0] last_count = PERIODIC_UPDATE_INTERVAL - 32'h0000_0001;
	wire interval_done = short_interval | (interval_count >= last_count);
	wire [`STAMP_BITS-1:0] next_time = time_count + 64'h0000_0000_0000_0001;

	assign policy = FIRST_EDGE_HOLD ? stamp_pkg::FIRST_EDGE : stamp_pkg::EVERY_EDGE;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			time_count <= `STAMP_RESET;
		end else begin
			time_count <= next_time;
		end
	end

	// Zero after reset matches the idle level, so no false edge follows reset
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			level_prev <= `INPUT_RESET;
		end else begin
			level_prev <= FILTERED_LEVEL;
		end
	end

	// ----------------------------------------
	// Per-input capture
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < `NUM_INPUTS; i++) begin : g_point
			wire rise_on = rise_edge[i] & RISE_CAPTURE_ENABLE[i];
			wire fall_on = fall_edge[i] & FALL_CAPTURE_ENABLE[i];
			wire hold = (policy == stamp_pkg::FIRST_EDGE);
			wire rise_take = rise_on & ~(hold & rise_held[i]);
			wire fall_take = fall_on & ~(hold & fall_held[i]);
			// Dropped under latch, or overwriting unacknowledged data otherwise
			wire lost = (rise_on & rise_held[i]) | (fall_on & fall_held[i]);
			wire clear_all = RST | RESET_ALL_EVENTS;
			// Set wins over a same-cycle acknowledge
			wire next_rise_held = ~clear_all & (rise_take | (rise_held[i] & ~ack[i]));
			wire next_fall_held = ~clear_all & (fall_take | (fall_held[i] & ~ack[i]));
			// Next values feed the report, so it carries this cycle's stamp
			wire next_fresh_bit = ~clear_all & (accept[i] | (fresh[i] & ~ack[i]));
			// Overflow survives acks; only a reset clears it
			wire next_overrun_bit = ~clear_all & (overrun[i] | lost);
			assign accept[i] = rise_take | fall_take;
			assign next_fresh[i] = next_fresh_bit;
			assign next_overrun[i] = next_overrun_bit;

			always_ff @(posedge SYS_CLK) begin
				rise_held[i] <= next_rise_held;
				fall_held[i] <= next_fall_held;
				fresh[i] <= next_fresh_bit;
				overrun[i] <= next_overrun_bit;
			end

			always_ff @(posedge SYS_CLK) begin
				if (clear_all) begin
					rising_edge_time[i] <= `STAMP_RESET;
				end else if (rise_take) begin
					rising_edge_time[i] <= time_count;
				end else if (ack[i]) begin
					rising_edge_time[i] <= `STAMP_RESET;
				end
			end

			always_ff @(posedge SYS_CLK) begin
				if (clear_all) begin
					falling_edge_time[i] <= `STAMP_RESET;
				end else if (fall_take) begin
					falling_edge_time[i] <= time_count;
				end else if (ack[i]) begin
					falling_edge_time[i] <= `STAMP_RESET;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Report timing
	// ----------------------------------------
	// Timer is not restarted by an event report
	wire [`INTERVAL_BITS-1:0] next_interval_count = interval_done ? `INTERVAL_RESET
		: interval_count + 32'h0000_0001;
	wire next_report = any_accept | interval_done;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			interval_count <= `INTERVAL_RESET;
		end else begin
			interval_count <= next_interval_count;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			REPORT_VALID <= 1'b0;
		end else begin
			REPORT_VALID <= next_report;
		end
	end

	// ----------------------------------------
	// Status words
	// ----------------------------------------
	// Upper halves read zero
	wire [`WORD_BITS-1:0] fault_word = {16'h0000, CHATTER_DETECTED};
	wire [`WORD_BITS-1:0] level_word = {16'h0000, FILTERED_LEVEL};
	wire [`WORD_BITS-1:0] fresh_word = {16'h0000, next_fresh};
	wire [`WORD_BITS-1:0] overrun_word = {16'h0000, next_overrun};

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			STATUS <= '0;
		end else begin
			STATUS.fault_bits <= fault_word;
			STATUS.level_bits <= level_word;
			STATUS.fresh_stamp_bits <= fresh_word;
			STATUS.stamp_overrun_bits <= overrun_word;
		end
	end

	// ----------------------------------------
	// Time words
	// ----------------------------------------
	// One reader at a time keeps the output mux to a single index
	wire [`STAMP_BITS-1:0] sel_rise = rising_edge_time[READ_INDEX];
	wire [`STAMP_BITS-1:0] sel_fall = falling_edge_time[READ_INDEX];

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RISE_TIME_LOW <= `WORD_RESET;
			RISE_TIME_HIGH <= `WORD_RESET;
			FALL_TIME_LOW <= `WORD_RESET;
			FALL_TIME_HIGH <= `WORD_RESET;
		end else begin
			RISE_TIME_LOW <= sel_rise[31:0];
			RISE_TIME_HIGH <= sel_rise[63:32];
			FALL_TIME_LOW <= sel_fall[31:0];
			FALL_TIME_HIGH <= sel_fall[63:32];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSTEM_TIME <= `STAMP_RESET;
		end else begin
			SYSTEM_TIME <= time_count;
		end
	end

endmodule : per_point_transition_timestamper

// ===== test/per_point_transition_timestamper_chk.sv
`timescale 1ns/1ns
// ----
// Port checker
// ----
module stamp_chk (
	input logic SYS_CLK,
	input logic RST,
	input logic [15:0] FILTERED_LEVEL,
	input logic [15:0] CHATTER_DETECTED,
	input logic [15:0] RISE_CAPTURE_ENABLE,
	input logic [15:0] FALL_CAPTURE_ENABLE,
	input logic FIRST_EDGE_HOLD,
	input logic [31:0] PERIODIC_UPDATE_INTERVAL,
	input logic [15:0] EVENT_ACKNOWLEDGE,
	input logic [15:0] NEW_SAMPLE_ACKNOWLEDGE,
	input logic RESET_ALL_EVENTS,
	input logic REPORT_VALID,
	input stamp_pkg::status_words_t STATUS
);
	logic [15:0] lv, acc, ackd;
	logic [31:0] gap;
	wire [15:0] fr = STATUS.fresh_stamp_bits[15:0];
	wire [15:0] ov = STATUS.stamp_overrun_bits[15:0];
	// Enabled edges only; the hold policy is judged separately
	always_ff @(posedge SYS_CLK) begin
		lv <= FILTERED_LEVEL;
		ackd <= EVENT_ACKNOWLEDGE & NEW_SAMPLE_ACKNOWLEDGE;
		acc <= RST ? 16'h0000 : (FILTERED_LEVEL & ~lv & RISE_CAPTURE_ENABLE)
			| (~FILTERED_LEVEL & lv & FALL_CAPTURE_ENABLE);
		gap <= (RST || REPORT_VALID) ? 32'h0000_0000 : gap + 32'h0000_0001;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	AST_EN: assert property (~|(fr & ~$past(fr) & ~acc)) else $error("fresh");
	AST_ALL: assert property (!$past(FIRST_EDGE_HOLD) |-> ~|(acc & ~fr))
		else $error("miss");
	AST_RPT: assert property (|acc && !$past(FIRST_EDGE_HOLD) |-> REPORT_VALID)
		else $error("rpt");
	AST_ACK: assert property (~|(fr & ackd & ~acc)) else $error("ack");
	AST_OVR: assert property ($past(RESET_ALL_EVENTS) || ~|($past(ov) & ~ov))
		else $error("ovr");
	AST_FLT: assert property (!$past(RST) |-> STATUS.fault_bits
		== {16'h0000, $past(CHATTER_DETECTED)}) else $error("flt");
	AST_LVL: assert property (!$past(RST) |-> STATUS.level_bits
		== {16'h0000, $past(FILTERED_LEVEL)}) else $error("lvl");
	AST_GAP: assert property (gap < PERIODIC_UPDATE_INTERVAL + 32'h0000_0002)
		else $error("gap");
	cover property (REPORT_VALID && |acc);
	cover property (|(ov & ~$past(ov)));
	cover property (|(ackd & $past(fr)));
endmodule : stamp_chk
bind per_point_transition_timestamper stamp_chk i_chk (.*);

// ===== test/stamp_ctrl_model.sv
`timescale 1ns/1ns
// ----
// Controller model
// ----
module stamp_ctrl_model (
	input logic clk,
	input logic rst,
	input logic go,
	input logic report,
	input logic [15:0] fresh,
	output logic [15:0] ack
);
	logic [15:0] copy;
	// Acks only copied bits, so unseen stamps survive a stall
	always_ff @(posedge clk) begin
		copy <= rst ? 16'h0000 : report ? fresh : copy & ~ack;
		ack <= (rst || !go) ? 16'h0000 : copy & ~ack;
	end
endmodule : stamp_ctrl_model

// ===== test/tb_per_point_transition_timestamper.sv
`timescale 1ns/1ns
// ----
// Bench
// ----
module tb_per_point_transition_timestamper;
	logic clk = 1'b0, rst = 1'b1, hold = 1'b0, rall = 1'b0, go = 1'b0, rv;
	logic [15:0] lvl = 16'h0000, cht = 16'h0000, ren = 16'h0000, fen = 16'h0000, pl, pc, ack;
	logic [3:0] idx = 4'h1;
	logic [31:0] rl, rh, fl, fh;
	logic [63:0] st;
	stamp_pkg::status_words_t s;
	int fails = 0, num_checks = 0;
	always #2 clk = ~clk;
	per_point_transition_timestamper i_dut (.SYS_CLK(clk), .RST(rst), .FILTERED_LEVEL(lvl),
		.CHATTER_DETECTED(cht), .RISE_CAPTURE_ENABLE(ren), .FALL_CAPTURE_ENABLE(fen),
		.FIRST_EDGE_HOLD(hold), .PERIODIC_UPDATE_INTERVAL(32'h0000_0018),
		.EVENT_ACKNOWLEDGE(ack), .NEW_SAMPLE_ACKNOWLEDGE(ack), .RESET_ALL_EVENTS(rall),
		.READ_INDEX(idx), .REPORT_VALID(rv), .STATUS(s), .RISE_TIME_LOW(rl),
		.RISE_TIME_HIGH(rh), .FALL_TIME_LOW(fl), .FALL_TIME_HIGH(fh), .SYSTEM_TIME(st));
	stamp_ctrl_model i_ctrl (.clk(clk), .rst(rst), .go(go), .report(rv),
		.fresh(s.fresh_stamp_bits[15:0]), .ack(ack));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
		if (g !== e) fails++;
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step
	task automatic results;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : results
	initial begin
		#20000 fails++;
		results();
	end
	initial begin
		void'($urandom(80));
		repeat (20) @(posedge clk);
		{rst, hold, ren, fen} <= {1'b0, 1'b1, 32'hffff_ffff};
		@(posedge clk) lvl <= 16'h0002;
		step(2);
		chk("fresh", 32'h0000_0002, s.fresh_stamp_bits);
		chk("rise", 32'h0000_0001, rl);
		chk("riseh", 32'h0000_0000, rh);
		chk("sys", 32'h0000_0002, st[31:0]);
		@(posedge clk) lvl <= 16'h0000;
		@(posedge clk) lvl <= 16'h0002;
		step(2);
		chk("ovr", 32'h0000_0002, s.stamp_overrun_bits);
		chk("held", 32'h0000_0001, rl);
		chk("fall", 32'h0000_0004, fl);
		chk("fallh", 32'h0000_0000, fh);
		@(posedge clk) go <= 1'b1;
		step(60);
		chk("ack", 32'h0000_0000, s.fresh_stamp_bits);
		chk("time", 32'h0000_0000, rl);
		chk("ftime", 32'h0000_0000, fl);
		$display("directed done");
		for (int i = 0; i < 400; i++) begin
			{pc, pl} = {cht, lvl};
			@(posedge clk) {lvl, cht, ren, fen} <= {$urandom, $urandom};
			{hold, go, idx} <= 6'($urandom);
			@(negedge clk);
			chk("flt", {16'h0000, pc}, s.fault_bits);
			chk("lvl", {16'h0000, pl}, s.level_bits);
		end
		@(posedge clk) rall <= 1'b1;
		@(posedge clk) rall <= 1'b0;
		step(1);
		chk("rall", 32'h0000_0000, s.stamp_overrun_bits);
		$display("random done");
		results();
	end
endmodule : tb_per_point_transition_timestamper
